/* pkt_seq_params.svh */
// register map, field positions and reset values of the packet sequencer
// Operation
// - style bit: 0 continuous, 1 packet
// - compat mode follows enable bit, reset off
// - beacon enable applies only to fixed length
// - 11-bit body size, low byte resets 0x40
// - filter compares own-station address
// - filter may also accept all-stations address
// - send on level event or non-empty queue
// - level event when count >= mark + 1
// - launch bit starts sequencer from idle
// - halt forces idle, reads zero
// - doze state picks standby or sleep
// - idle route field picks start target
// - end of action: idle or low power
// - wake event routes to transmit or receive
// - frame sent routes to end or receive
// - length style: 0 fixed, 1 variable
// - match mode 01 own, 10 own or all
`ifndef PKT_SEQ_PARAMS_SVH
`define PKT_SEQ_PARAMS_SVH

// ====
// register offsets
`define OFS_PACKET_CONTROL_A 8'h30
`define OFS_PACKET_CONTROL_B 8'h31
`define OFS_PAYLOAD_LENGTH_LOW 8'h32
`define OFS_OWN_STATION_ADDRESS 8'h33
`define OFS_ALL_STATIONS_ADDRESS 8'h34
`define OFS_QUEUE_THRESHOLD_CONTROL 8'h35
`define OFS_SEQUENCER_CONTROL_A 8'h36
`define OFS_SEQUENCER_STATUS 8'h3f

// ====
// field positions
`define BIT_LENGTH_STYLE 0
`define BIT_MATCH_LO 1
`define BIT_MATCH_HI 2
`define BIT_PROC_STYLE 6
`define BIT_HOME_COMPAT 5
`define BIT_POWER_FRAME 4
`define BIT_BEACON 3
`define BIT_SIZE_HI_TOP 2
`define BIT_SEND_TRIGGER 7
`define BIT_MARK_TOP 5
`define BIT_LAUNCH 7
`define BIT_HALT 6
`define BIT_DOZE_STATE 5
`define BIT_IDLE_ROUTE_HI 4
`define BIT_IDLE_ROUTE_LO 3
`define BIT_END_TARGET 2
`define BIT_DOZE_ROUTE 1
`define BIT_SEND_ROUTE 0

// ====
// reset values
`define RST_PACKET_CONTROL_A 8'h01
`define RST_PACKET_CONTROL_B 8'h40
`define RST_PAYLOAD_LOW 8'h40
`define RST_OWN_STATION 8'h00
`define RST_ALL_STATIONS 8'h00
`define RST_QUEUE_THRESHOLD 8'h0f
`define RST_SEQ_CONTROL 8'h00

// ====
// field encodings
`define MATCH_OFF 2'h0
`define MATCH_OWN 2'h1
`define MATCH_OWN_OR_ALL 2'h2
`define ROUTE_END 2'h0
`define ROUTE_RX 2'h1
`define ROUTE_TX 2'h2
`define ROUTE_WAIT 2'h3

`endif

/* pkt_seq_pkg.sv */
// types shared by the packet sequencer files
package pkt_seq_pkg;

    typedef enum logic [2:0] {
        seq_idle,
        seq_low_power,
        seq_receive,
        seq_transmit,
        seq_await_queue
    } seq_state_t;

    typedef enum logic [1:0] {
        chip_sleep,
        chip_standby,
        chip_active
    } chip_mode_t;

    // software-facing register port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // events from timers and datapath
    typedef struct packed {
        logic wake_timer;
        logic frame_sent;
        logic rx_done;
    } seq_event_t;

endpackage

/* seq_fsm.sv */
// top level sequencer state machine
`timescale 1ns/1ps
`include "pkt_seq_params.svh"

module seq_fsm (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // commands
    input wire logic launch,
    input wire logic halt,
    // configuration
    input wire logic [1:0] after_idle_route,
    input wire logic end_of_action_target,
    input wire logic after_doze_route,
    input wire logic after_send_route,
    input wire logic doze_chip_state,
    input wire logic send_ready,
    // events
    input wire pkt_seq_pkg::seq_event_t events,
    // state
    output pkt_seq_pkg::seq_state_t state,
    output pkt_seq_pkg::chip_mode_t chip_mode,
    output logic launch_taken
);

    pkt_seq_pkg::seq_state_t state_reg;
    pkt_seq_pkg::seq_state_t state_next;
    pkt_seq_pkg::seq_state_t end_target;

    assign end_target = end_of_action_target ? pkt_seq_pkg::seq_low_power
                                             : pkt_seq_pkg::seq_idle;

    always_comb begin
        state_next = state_reg;
        launch_taken = 1'b0;
        unique case (state_reg)
            pkt_seq_pkg::seq_idle: begin
                if (launch) begin
                    launch_taken = 1'b1;
                    unique case (after_idle_route)
                        `ROUTE_END: state_next = end_target;
                        `ROUTE_RX: state_next = pkt_seq_pkg::seq_receive;
                        `ROUTE_TX: state_next = pkt_seq_pkg::seq_transmit;
                        `ROUTE_WAIT: state_next = pkt_seq_pkg::seq_await_queue;
                    endcase
                end
            end
            pkt_seq_pkg::seq_low_power: begin
                if (events.wake_timer) begin
                    state_next = after_doze_route ? pkt_seq_pkg::seq_receive
                                                  : pkt_seq_pkg::seq_transmit;
                end
            end
            pkt_seq_pkg::seq_receive: begin
                if (events.rx_done) begin
                    state_next = end_target;
                end
            end
            pkt_seq_pkg::seq_transmit: begin
                if (events.frame_sent) begin
                    state_next = after_send_route ? pkt_seq_pkg::seq_receive
                                                  : end_target;
                end
            end
            pkt_seq_pkg::seq_await_queue: begin
                if (send_ready) begin
                    state_next = pkt_seq_pkg::seq_transmit;
                end
            end
            default: state_next = pkt_seq_pkg::seq_idle;
        endcase
        if (halt) begin
            state_next = pkt_seq_pkg::seq_idle;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= pkt_seq_pkg::seq_idle;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chip_mode <= pkt_seq_pkg::chip_standby;
        end else if (state_next == pkt_seq_pkg::seq_low_power) begin
            chip_mode <= doze_chip_state ? pkt_seq_pkg::chip_sleep
                                         : pkt_seq_pkg::chip_standby;
        end else if (state_next == pkt_seq_pkg::seq_idle) begin
            chip_mode <= pkt_seq_pkg::chip_standby;
        end else begin
            chip_mode <= pkt_seq_pkg::chip_active;
        end
    end

    assign state = state_reg;

endmodule

/* packet_engine_sequencer.sv */
// packet engine configuration registers and sequencer top
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "pkt_seq_params.svh"

module packet_engine_sequencer #(
    parameter int QUEUE_COUNT_W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // queue and datapath status
    input wire logic [QUEUE_COUNT_W-1:0] queue_count,
    input wire logic rx_addr_valid,
    input wire logic [7:0] rx_addr_byte,
    // sequencer events
    input wire logic wake_timer,
    input wire logic frame_sent_event,
    input wire logic rx_done,
    // configuration to datapath
    output logic processing_style_select,
    output logic home_compat_enable,
    output logic compat_power_frame,
    output logic beacon_repeat_enable,
    output logic length_style,
    output logic [10:0] frame_body_size,
    output logic [7:0] own_station_id,
    output logic [7:0] all_stations_id,
    output logic [1:0] station_match_mode,
    // status to datapath
    output logic queue_level_event,
    output logic queue_empty_flag,
    output logic send_start,
    output logic addr_accept,
    output pkt_seq_pkg::seq_state_t seq_state,
    output pkt_seq_pkg::chip_mode_t chip_mode
);

    // ====
    // register storage
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] size_low_reg;
    logic [7:0] own_reg;
    logic [7:0] all_reg;
    logic [7:0] thresh_reg;
    logic [7:0] seq_ctrl_reg;
    logic launch_reg;
    logic halt_pulse;
    logic launch_taken;
    logic send_ready;
    pkt_seq_pkg::reg_req_t req;
    pkt_seq_pkg::seq_event_t events;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign events = '{wake_timer: wake_timer, frame_sent: frame_sent_event,
                      rx_done: rx_done};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // writable bits only, unused stay zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_a_reg <= `RST_PACKET_CONTROL_A;
        end else if (req.wr && hit(req.addr, `OFS_PACKET_CONTROL_A)) begin
            ctrl_a_reg <= {5'h00, req.wdata[`BIT_MATCH_HI:`BIT_LENGTH_STYLE]};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_b_reg <= `RST_PACKET_CONTROL_B;
        end else if (req.wr && hit(req.addr, `OFS_PACKET_CONTROL_B)) begin
            ctrl_b_reg <= {1'b0, req.wdata[`BIT_PROC_STYLE:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            size_low_reg <= `RST_PAYLOAD_LOW;
        end else if (req.wr && hit(req.addr, `OFS_PAYLOAD_LENGTH_LOW)) begin
            size_low_reg <= req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            own_reg <= `RST_OWN_STATION;
        end else if (req.wr && hit(req.addr, `OFS_OWN_STATION_ADDRESS)) begin
            own_reg <= req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            all_reg <= `RST_ALL_STATIONS;
        end else if (req.wr && hit(req.addr, `OFS_ALL_STATIONS_ADDRESS)) begin
            all_reg <= req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            thresh_reg <= `RST_QUEUE_THRESHOLD;
        end else if (req.wr && hit(req.addr, `OFS_QUEUE_THRESHOLD_CONTROL)) begin
            thresh_reg <= {req.wdata[`BIT_SEND_TRIGGER], 1'b0,
                           req.wdata[`BIT_MARK_TOP:0]};
        end
    end

    // plain config bits of the sequencer register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            seq_ctrl_reg <= `RST_SEQ_CONTROL;
        end else if (req.wr && hit(req.addr, `OFS_SEQUENCER_CONTROL_A)) begin
            seq_ctrl_reg <= {2'h0, req.wdata[`BIT_DOZE_STATE:0]};
        end
    end

    // launch held until taken or halted; new write wins over clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            launch_reg <= 1'b0;
        end else if (req.wr && hit(req.addr, `OFS_SEQUENCER_CONTROL_A)
                     && req.wdata[`BIT_LAUNCH]) begin
            launch_reg <= 1'b1;
        end else if (launch_taken || halt_pulse) begin
            launch_reg <= 1'b0;
        end
    end

    // halt is a write pulse only
    assign halt_pulse = req.wr && hit(req.addr, `OFS_SEQUENCER_CONTROL_A)
                        && req.wdata[`BIT_HALT];

    // ====
    // read path
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                `OFS_PACKET_CONTROL_A: reg_rdata <= ctrl_a_reg;
                `OFS_PACKET_CONTROL_B: reg_rdata <= ctrl_b_reg;
                `OFS_PAYLOAD_LENGTH_LOW: reg_rdata <= size_low_reg;
                `OFS_OWN_STATION_ADDRESS: reg_rdata <= own_reg;
                `OFS_ALL_STATIONS_ADDRESS: reg_rdata <= all_reg;
                `OFS_QUEUE_THRESHOLD_CONTROL: reg_rdata <= thresh_reg;
                // halt reads zero, launch shows pending
                `OFS_SEQUENCER_CONTROL_A:
                    reg_rdata <= {launch_reg, 1'b0, seq_ctrl_reg[5:0]};
                `OFS_SEQUENCER_STATUS:
                    reg_rdata <= {queue_level_event, queue_empty_flag,
                                  1'b0, chip_mode, seq_state};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ====
    // configuration outputs
    // processing style
    assign processing_style_select = ctrl_b_reg[`BIT_PROC_STYLE];
    assign home_compat_enable = ctrl_b_reg[`BIT_HOME_COMPAT];
    assign compat_power_frame = ctrl_b_reg[`BIT_POWER_FRAME];
    assign length_style = ctrl_a_reg[`BIT_LENGTH_STYLE];
    assign beacon_repeat_enable = ctrl_b_reg[`BIT_BEACON] && !length_style;
    assign frame_body_size = {ctrl_b_reg[`BIT_SIZE_HI_TOP:0], size_low_reg};
    assign own_station_id = own_reg;
    assign all_stations_id = all_reg;
    assign station_match_mode = ctrl_a_reg[`BIT_MATCH_HI:`BIT_MATCH_LO];

    // ====
    // queue level and send trigger
    // count >= mark + 1
    assign queue_level_event =
        {1'b0, queue_count} > {{(QUEUE_COUNT_W-5){1'b0}},
                               thresh_reg[`BIT_MARK_TOP:0]};
    assign queue_empty_flag = (queue_count == '0);
    assign send_ready = thresh_reg[`BIT_SEND_TRIGGER] ? !queue_empty_flag
                                                      : queue_level_event;
    assign send_start = send_ready && processing_style_select
                        && (seq_state == pkt_seq_pkg::seq_transmit);

    // ====
    // address filter
    // station match modes
    always_comb begin
        unique case (station_match_mode)
            `MATCH_OWN: addr_accept = rx_addr_valid
                                      && (rx_addr_byte == own_reg);
            `MATCH_OWN_OR_ALL: addr_accept = rx_addr_valid
                && (rx_addr_byte == own_reg || rx_addr_byte == all_reg);
            `MATCH_OFF: addr_accept = rx_addr_valid;
            default: addr_accept = 1'b0;
        endcase
    end

    // ====
    // sequencer
    // launch into the state machine
    seq_fsm u_seq_fsm (
        .clk(clk),
        .reset_n(reset_n),
        .launch(launch_reg),
        .halt(halt_pulse),
        .after_idle_route(seq_ctrl_reg[`BIT_IDLE_ROUTE_HI:`BIT_IDLE_ROUTE_LO]),
        .end_of_action_target(seq_ctrl_reg[`BIT_END_TARGET]),
        .after_doze_route(seq_ctrl_reg[`BIT_DOZE_ROUTE]),
        .after_send_route(seq_ctrl_reg[`BIT_SEND_ROUTE]),
        .doze_chip_state(seq_ctrl_reg[`BIT_DOZE_STATE]),
        .send_ready(send_ready),
        .events(events),
        .state(seq_state),
        .chip_mode(chip_mode),
        .launch_taken(launch_taken)
    );

endmodule

/* packet_engine_sequencer_asserts.sv */
// concurrent checks on the packet sequencer top ports
`timescale 1ns/1ps
module packet_engine_sequencer_asserts #(
    parameter int QUEUE_COUNT_W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // datapath side
    input wire logic [QUEUE_COUNT_W-1:0] queue_count,
    input wire logic rx_addr_valid,
    input wire logic [7:0] rx_addr_byte,
    input wire logic wake_timer,
    input wire logic frame_sent_event,
    // status
    input wire logic processing_style_select,
    input wire logic beacon_repeat_enable,
    input wire logic length_style,
    input wire logic [7:0] own_station_id,
    input wire logic [7:0] all_stations_id,
    input wire logic [1:0] station_match_mode,
    input wire logic queue_empty_flag,
    input wire logic send_start,
    input wire logic addr_accept,
    input wire pkt_seq_pkg::seq_state_t seq_state,
    input wire pkt_seq_pkg::chip_mode_t chip_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ====
    // sequencer commands
    sequence s_launch(logic [1:0] route);
        reg_wr && reg_addr == 8'h36 && reg_wdata[7:6] == 2'h2 &&
            reg_wdata[4:3] == route && seq_state == pkt_seq_pkg::seq_idle;
    endsequence
    sequence s_halt;
        reg_wr && reg_addr == 8'h36 && reg_wdata[7:6] == 2'h1;
    endsequence
    // launch is pending one cycle before the state moves
    property p_launch_tx;
        s_launch(2'h2) |=> ##1 seq_state == pkt_seq_pkg::seq_transmit;
    endproperty
    a_launch_tx: assert property (p_launch_tx) else $error("no tx");
    property p_launch_rx;
        s_launch(2'h1) |=> ##1 seq_state == pkt_seq_pkg::seq_receive;
    endproperty
    a_launch_rx: assert property (p_launch_rx) else $error("no rx");
    property p_halt;
        s_halt |=> ##[0:1] seq_state == pkt_seq_pkg::seq_idle;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_frame_sent;
        seq_state == pkt_seq_pkg::seq_transmit && frame_sent_event
            |=> ##[0:1] seq_state != pkt_seq_pkg::seq_transmit;
    endproperty
    a_frame_sent: assert property (p_frame_sent) else $error("stuck in tx");
    property p_wake;
        seq_state == pkt_seq_pkg::seq_low_power && wake_timer |=> ##[0:1]
            seq_state inside {pkt_seq_pkg::seq_transmit, pkt_seq_pkg::seq_receive};
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_doze_mode;
        seq_state == pkt_seq_pkg::seq_low_power
            |-> chip_mode != pkt_seq_pkg::chip_active;
    endproperty
    a_doze_mode: assert property (p_doze_mode) else $error("active in doze");
    property p_idle_mode;
        seq_state == pkt_seq_pkg::seq_idle |-> chip_mode == pkt_seq_pkg::chip_standby;
    endproperty
    a_idle_mode: assert property (p_idle_mode) else $error("idle mode");

    // ====
    // register port and datapath status
    property p_rdata_quiet;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("stray rdata");
    property p_readback;
        $past(reg_rd) && $past(reg_addr) == 8'h33 |-> reg_rdata == own_station_id;
    endproperty
    a_readback: assert property (p_readback) else $error("own id");
    property p_send;
        send_start |-> seq_state == pkt_seq_pkg::seq_transmit &&
            processing_style_select && !queue_empty_flag;
    endproperty
    a_send: assert property (p_send) else $error("bad send start");
    property p_empty;
        queue_empty_flag == (queue_count == '0);
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag");
    property p_beacon;
        beacon_repeat_enable |-> !length_style;
    endproperty
    a_beacon: assert property (p_beacon) else $error("beacon");
    property p_own_match;
        addr_accept && station_match_mode == 2'h1 |-> rx_addr_byte == own_station_id;
    endproperty
    a_own_match: assert property (p_own_match) else $error("foreign");
    property p_all_match;
        station_match_mode == 2'h2 && rx_addr_valid &&
            rx_addr_byte == all_stations_id |-> addr_accept;
    endproperty
    a_all_match: assert property (p_all_match) else $error("all lost");
endmodule

bind packet_engine_sequencer packet_engine_sequencer_asserts #(
    .QUEUE_COUNT_W(QUEUE_COUNT_W)
) u_packet_engine_sequencer_asserts (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .queue_count, .rx_addr_valid, .rx_addr_byte, .wake_timer,
    .frame_sent_event, .processing_style_select, .beacon_repeat_enable,
    .length_style, .own_station_id, .all_stations_id, .station_match_mode,
    .queue_empty_flag, .send_start, .addr_accept, .seq_state, .chip_mode
);

/* datapath_model.sv */
// stand-in for the modem datapath, queue and timers
`timescale 1ns/1ps
module datapath_model #(
    parameter int QUEUE_COUNT_W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // from the sequencer
    input wire logic send_start,
    // queue and address status
    output logic [QUEUE_COUNT_W-1:0] queue_count = '0,
    output logic rx_addr_valid = '0,
    output logic [7:0] rx_addr_byte = '0,
    // timer and datapath events
    output logic wake_timer = '0,
    output logic frame_sent_event = '0,
    output logic rx_done = '0
);
    // send start to frame sent, cycles
    int lat = 2;
    int left = 0;

    // ====
    // frame transmission
    // send on request
    // zeroing the queue drops send_start, so no second frame
    always @(posedge clk) begin
        if (frame_sent_event)
            frame_sent_event <= 1'h0;
        if (!reset_n)
            left <= 0;
        else if (left == 1) begin
            frame_sent_event <= 1'h1;
            queue_count <= '0;
            left <= 0;
        end else if (left > 1)
            left <= left - 1;
        else if (send_start)
            left <= lat;
    end

    // ====
    // bench controls
    task automatic put_count(input int n);
        @(posedge clk);
        queue_count <= n[QUEUE_COUNT_W-1:0];
        #1;
    endtask

    // kind 0 wake timer, 2 receive done
    task automatic pulse(input int kind);
        @(posedge clk);
        wake_timer <= (kind == 0);
        rx_done <= (kind == 2);
        @(posedge clk);
        wake_timer <= 1'h0;
        rx_done <= 1'h0;
        #1;
    endtask

    task automatic show_addr(input logic [7:0] b);
        @(posedge clk);
        rx_addr_valid <= 1'h1;
        rx_addr_byte <= b;
        #1;
    endtask
endmodule

/* tb_top.sv */
// self-checking bench for the packet engine sequencer
`timescale 1ns/1ps
module tb_top;
    logic clk, reset_n, reg_wr, reg_rd, rx_addr_valid, wake_timer, rx_done;
    logic frame_sent_event, processing_style_select, home_compat_enable;
    logic compat_power_frame, beacon_repeat_enable, length_style;
    logic queue_level_event, queue_empty_flag, send_start, addr_accept;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_addr_byte;
    logic [7:0] own_station_id, all_stations_id;
    logic [6:0] queue_count;
    logic [10:0] frame_body_size;
    logic [1:0] station_match_mode;
    pkt_seq_pkg::seq_state_t seq_state;
    pkt_seq_pkg::chip_mode_t chip_mode;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;

    packet_engine_sequencer #(.QUEUE_COUNT_W(7)) u_packet_engine_sequencer (
        .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .queue_count, .rx_addr_valid, .rx_addr_byte, .wake_timer,
        .frame_sent_event, .rx_done, .processing_style_select,
        .home_compat_enable, .compat_power_frame, .beacon_repeat_enable,
        .length_style, .frame_body_size, .own_station_id, .all_stations_id,
        .station_match_mode, .queue_level_event, .queue_empty_flag,
        .send_start, .addr_accept, .seq_state, .chip_mode);
    datapath_model #(.QUEUE_COUNT_W(7)) u_datapath_model (
        .clk, .reset_n, .send_start, .queue_count, .rx_addr_valid,
        .rx_addr_byte, .wake_timer, .frame_sent_event, .rx_done);

    // ====
    // clock, watchdog, verdict
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ====
    // bus and compare helpers
    task automatic chk(input logic [10:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wait_state(input pkt_seq_pkg::seq_state_t s);
        for (int i = 0; i < 40 && seq_state !== s; i++) begin
            @(posedge clk);
            #1;
        end
        chk(seq_state, s);
    endtask

    // ====
    // scenarios
    task automatic t_reset;
        logic [7:0] ofs [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
            8'h36, 8'h20};
        logic [7:0] val [8] = '{8'h01, 8'h40, 8'h40, 8'h00, 8'h00, 8'h0f,
            8'h00, 8'h00};
        for (int i = 0; i < 8; i++)
            rdchk(ofs[i], val[i]);
        chk(processing_style_select, 1'h1);
        chk(home_compat_enable, 1'h0);
        chk(frame_body_size, 11'h040);
        chk(length_style, 1'h1);
        chk(seq_state, pkt_seq_pkg::seq_idle);
    endtask
    task automatic t_regs;
        wr(8'h31, 8'hff);
        rdchk(8'h31, 8'h7f);
        chk(home_compat_enable, 1'h1);
        chk(compat_power_frame, 1'h1);
        chk(beacon_repeat_enable, 1'h0);
        wr(8'h30, 8'h00);
        chk(beacon_repeat_enable, 1'h1);
        chk(length_style, 1'h0);
        wr(8'h32, 8'ha5);
        chk(frame_body_size, 11'h7a5);
        wr(8'h35, 8'hff);
        rdchk(8'h35, 8'hbf);
        wr(8'h20, 8'h5a);
        rdchk(8'h20, 8'h00);
        wr(8'h31, 8'h00);
        chk(processing_style_select, 1'h0);
        wr(8'h31, 8'h40);
    endtask
    task automatic t_level;
        // one below and at mark + 1
        for (int i = 0; i < 4; i++) begin
            wr(8'h35, (i < 2) ? 8'h05 : 8'h3f);
            u_datapath_model.put_count((i < 2 ? 5 : 63) + i % 2);
            chk(queue_level_event, i[0]);
            chk(queue_empty_flag, 1'h0);
        end
    endtask
    task automatic t_addr;
        logic [7:0] seen [3] = '{8'h12, 8'h7e, 8'h33};
        logic [11:0] acc = 12'hf30;
        wr(8'h33, 8'h12);
        wr(8'h34, 8'h7e);
        rdchk(8'h33, 8'h12);
        chk(all_stations_id, 8'h7e);
        for (int m = 0; m < 4; m++) begin
            wr(8'h30, {5'h00, m[1:0], 1'h1});
            chk(station_match_mode, m[1:0]);
            for (int b = 0; b < 3; b++) begin
                u_datapath_model.show_addr(seen[b]);
                chk(addr_accept, acc[11 - 3 * m - b]);
            end
        end
    endtask
    task automatic t_seq;
        wr(8'h35, 8'h05);
        u_datapath_model.put_count(0);
        chk(queue_empty_flag, 1'h1);
        // launch only in standby
        chk(chip_mode, pkt_seq_pkg::chip_standby);
        wr(8'h36, 8'h96);
        chk(seq_state, pkt_seq_pkg::seq_idle);
        @(posedge clk);
        #1;
        chk(seq_state, pkt_seq_pkg::seq_transmit);
        chk(send_start, 1'h0);
        rdchk(8'h36, 8'h16);
        u_datapath_model.put_count(6);
        chk(send_start, 1'h1);
        wait_state(pkt_seq_pkg::seq_low_power);
        chk(chip_mode, pkt_seq_pkg::chip_standby);
        u_datapath_model.pulse(0);
        wait_state(pkt_seq_pkg::seq_receive);
        wr(8'h36, 8'h40);
        wait_state(pkt_seq_pkg::seq_idle);
        rdchk(8'h36, 8'h00);
        u_datapath_model.lat = 12;
        wr(8'h36, 8'had);
        wait_state(pkt_seq_pkg::seq_receive);
        u_datapath_model.pulse(2);
        wait_state(pkt_seq_pkg::seq_low_power);
        chk(chip_mode, pkt_seq_pkg::chip_sleep);
        u_datapath_model.pulse(0);
        wait_state(pkt_seq_pkg::seq_transmit);
        u_datapath_model.put_count(6);
        wait_state(pkt_seq_pkg::seq_receive);
        wr(8'h36, 8'h40);
        wait_state(pkt_seq_pkg::seq_idle);
    endtask
    task automatic t_routes;
        pkt_seq_pkg::seq_state_t st [4] = '{pkt_seq_pkg::seq_idle,
            pkt_seq_pkg::seq_receive, pkt_seq_pkg::seq_transmit,
            pkt_seq_pkg::seq_await_queue};
        u_datapath_model.lat = 2;
        wr(8'h35, 8'h80);
        u_datapath_model.put_count(0);
        for (int r = 0; r < 4; r++) begin
            wr(8'h36, {3'h4, r[1:0], 3'h0});
            wait_state(st[r]);
            if (r == 3) begin
                u_datapath_model.put_count(1);
                wait_state(pkt_seq_pkg::seq_transmit);
                wait_state(pkt_seq_pkg::seq_idle);
            end
            wr(8'h36, 8'h40);
            wait_state(pkt_seq_pkg::seq_idle);
        end
    endtask

    // ====
    // main sequence
    initial begin
        reset_n = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'h1;
        t_reset();
        t_regs();
        t_level();
        t_addr();
        t_seq();
        t_routes();
        print_verdict();
    end
endmodule
